/* shared/qbp_pkg.sv */
// Shared constants for the quasi-bidirectional port with address mode.
package qbp_pkg;
  // ==========================================================
  // Port geometry and reset values
  localparam int unsigned PORT_WIDTH = 8;
  localparam logic [7:0] LATCH_RESET = 8'hFF;
  // ==========================================================
  // Timing of the strong high transition drive
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned BOOST_TIME_NS = 20;
  localparam int unsigned BOOST_CYCLES =
    (BOOST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] BOOST_ZERO = 4'h0;
  localparam logic [3:0] BOOST_ONE = 4'h1;
endpackage : qbp_pkg

/* core/qbp_pin_boost.sv */
// One strong-high transition timer, shared shape for every pin.
`timescale 1ns/1ps
module qbp_pin_boost #(
  parameter int unsigned CYCLES = qbp_pkg::BOOST_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // Trigger and drive
  input wire logic start_in,
  output logic boost_out
);
  // The countdown is four bits wide, so longer drives cannot be served.
  if (CYCLES < 1 || CYCLES > 15) begin : g_bad_cycles
    $error("qbp_pin_boost: CYCLES must be 1..15.");
  end

  localparam logic [3:0] LOAD = 4'(CYCLES);
  logic [3:0] count_reg;
  logic [3:0] count_next;

  // ==========================================================
  // Countdown
  // Restarting on a fresh trigger keeps repeated 0-to-1 writes honest.
  assign count_next = start_in ? LOAD :
    (count_reg != qbp_pkg::BOOST_ZERO) ? count_reg - qbp_pkg::BOOST_ONE :
    count_reg;
  assign boost_out = (count_reg != qbp_pkg::BOOST_ZERO);

  // Counter register.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count_reg <= qbp_pkg::BOOST_ZERO;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule : qbp_pin_boost

/* core/qbp_port.sv */
// Eight-bit quasi-bidirectional port with low address byte mode.
`timescale 1ns/1ps
module qbp_port #(
  parameter int unsigned WIDTH = qbp_pkg::PORT_WIDTH
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // Software latch write
  input wire logic latch_wr_in,
  input wire logic [7:0] latch_wdata_in,
  output logic [7:0] latch_out,
  // Address mode
  input wire logic address_bus_select_in,
  input wire logic [7:0] mem_addr_in,
  // Pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_out,
  output logic [7:0] pin_pullup_out,
  // Pin readback
  output logic [7:0] pin_level_out
);
  // ==========================================================
  // Parameter check
  // The pin ports are fixed at one byte, so only that width is served.
  if (WIDTH != qbp_pkg::PORT_WIDTH) begin : g_bad_width
    $error("qbp_port: WIDTH must be 8.");
  end

  logic [7:0] latch_reg;
  logic [7:0] latch_next;
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  logic [7:0] level_reg;
  logic [7:0] drive_val;
  logic [7:0] rise_start;
  logic [7:0] boost;
  logic [7:0] addr_drive;

  // ==========================================================
  // Latch
  // per-bit latch
  assign latch_next = latch_wr_in ? latch_wdata_in : latch_reg;
  assign rise_start = latch_wr_in ? (latch_wdata_in & ~latch_reg) : 8'h00;

  // Latch register, all ones after reset.
  // reset to ones
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      latch_reg <= qbp_pkg::LATCH_RESET;
    end else begin
      latch_reg <= latch_next;
    end
  end
  assign latch_out = latch_reg;

  // ==========================================================
  // Strong-high transition timers, one per pin
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_boost
      qbp_pin_boost #(.CYCLES(qbp_pkg::BOOST_CYCLES)) u_boost (
        .clk_sys_in(clk_sys_in),
        .arst_n_in(arst_n_in),
        .start_in(rise_start[gi]),
        .boost_out(boost[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Pin drive
  // bit n to pin n; address drives both levels strongly
  assign addr_drive = mem_addr_in;
  assign drive_val = address_bus_select_in ? addr_drive : latch_reg;
  // strong low on zero, weak on one once the strong-high boost ends
  assign pin_out = drive_val;
  assign pin_oe_out = address_bus_select_in ? 8'hFF :
    (~latch_reg | (boost & latch_reg));
  // Weak pullup present in port mode when the latch releases the pin; off in address mode.
  assign pin_pullup_out = address_bus_select_in ? 8'h00 : latch_reg;

  // ==========================================================
  // Pin readback through a three-stage synchroniser
  // real pin level
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync1_reg <= qbp_pkg::LATCH_RESET;
      sync2_reg <= qbp_pkg::LATCH_RESET;
      level_reg <= qbp_pkg::LATCH_RESET;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      level_reg <= sync2_reg;
    end
  end
  assign pin_level_out = level_reg;

  // ==========================================================
  // Checks
  property p_reset_ones;
    @(posedge clk_sys_in) $rose(arst_n_in) |->
      latch_reg == qbp_pkg::LATCH_RESET &&
      pin_level_out == qbp_pkg::LATCH_RESET;
  endproperty
  a_reset_ones: assert property (p_reset_ones)
    else $error("Latch not all ones after reset.");

  property p_write_stores;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
      latch_wr_in |=> latch_out == $past(latch_wdata_in);
  endproperty
  a_write_stores: assert property (p_write_stores)
    else $error("Latch did not take written value.");

  property p_low_strong;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
      !address_bus_select_in |->
        (pin_oe_out | latch_reg) == 8'hFF &&
        (pin_out & ~latch_reg) == 8'h00;
  endproperty
  a_low_strong: assert property (p_low_strong)
    else $error("Zero latch not driving strong low.");

  // Helper for the transition checks: which bits a write takes from zero
  // to one, and how many edges have passed since the latest such write.
  // The quiet count saturates so that a long idle spell never wraps.
  localparam logic [3:0] QUIET_MAX = 4'hF;
  localparam logic [3:0] QUIET_STEP = 4'h1;
  localparam logic [3:0] QUIET_ZERO = 4'h0;
  localparam logic [3:0] BOOST_LEN = 4'(qbp_pkg::BOOST_CYCLES);
  logic [7:0] chk_rise;
  logic [3:0] quiet_reg;
  logic [3:0] quiet_next;
  assign chk_rise = latch_wr_in ? (latch_wdata_in & ~latch_reg) : 8'h00;
  assign quiet_next = (chk_rise != 8'h00) ? QUIET_ZERO :
    (quiet_reg == QUIET_MAX) ? quiet_reg : quiet_reg + QUIET_STEP;

  // Quiet counter, idle and saturated after reset.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      quiet_reg <= QUIET_MAX;
    end else begin
      quiet_reg <= quiet_next;
    end
  end

  sequence s_rise_write;
    !address_bus_select_in && latch_wr_in && (chk_rise != 8'h00);
  endsequence
  sequence s_strong_high;
    ((pin_oe_out & $past(chk_rise)) == $past(chk_rise)) &&
      ((pin_out & $past(chk_rise)) == $past(chk_rise));
  endsequence
  property p_boost;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
      s_rise_write ##1 !address_bus_select_in |-> s_strong_high;
  endproperty
  a_boost: assert property (p_boost)
    else $error("Zero-to-one write gave no strong high.");

  property p_boost_ends;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
      (!address_bus_select_in && quiet_reg >= BOOST_LEN) |->
        (pin_oe_out & latch_reg) == 8'h00;
  endproperty
  a_boost_ends: assert property (p_boost_ends)
    else $error("Strong high lasted too long.");

  property p_input_weak;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
      !address_bus_select_in |->
        (pin_oe_out & latch_reg & ~boost) == 8'h00 &&
        (pin_pullup_out & latch_reg) == latch_reg;
  endproperty
  a_input_weak: assert property (p_input_weak)
    else $error("Input pin not released.");

  property p_addr_no_pullup;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
      address_bus_select_in |-> pin_pullup_out == 8'h00;
  endproperty
  a_addr_no_pullup: assert property (p_addr_no_pullup)
    else $error("Weak pullup left on in address mode.");

  property p_addr_low;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
      address_bus_select_in |-> pin_out[4:0] == mem_addr_in[4:0];
  endproperty
  a_addr_low: assert property (p_addr_low)
    else $error("Address bits 0-4 wrong.");

  property p_addr_high;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
      address_bus_select_in |->
        pin_out[7:5] == mem_addr_in[7:5] && pin_oe_out == 8'hFF;
  endproperty
  a_addr_high: assert property (p_addr_high)
    else $error("Address bits 5-7 wrong.");

  property p_mode_sel;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
      !address_bus_select_in |-> pin_out == latch_reg;
  endproperty
  a_mode_sel: assert property (p_mode_sel)
    else $error("Port mode not driving latch.");

  property p_readback;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
      ##3 1 |-> pin_level_out == $past(pin_in, 3);
  endproperty
  a_readback: assert property (p_readback)
    else $error("Pin level readback wrong.");
endmodule : qbp_port

/* dv/qbp_pin_model.sv */
// Far-side pin model: resolves each pin wire from all of its drivers.
`timescale 1ns/1ps
module qbp_pin_model (
  // Port side drivers
  input wire logic [7:0] pin_out_in,
  input wire logic [7:0] pin_oe_in,
  input wire logic [7:0] pin_pullup_in,
  // Outside circuit drivers
  input wire logic [7:0] ext_en_in,
  input wire logic [7:0] ext_val_in,
  // Resolved wire level
  output logic [7:0] wire_out
);
  // ==========================================================
  // Wire resolution
  // Strong drive wins, then the outside source, then the weak pullup.
  // An undriven wire with no pullup is read low, which is a limitation.
  // weak pullup overridden
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe_in[i]) wire_out[i] = pin_out_in[i];
      else if (ext_en_in[i]) wire_out[i] = ext_val_in[i];
      else wire_out[i] = pin_pullup_in[i];
    end
  end
endmodule : qbp_pin_model

/* dv/tb_top.sv */
// Self-checking bench for the quasi-bidirectional port.
`timescale 1ns/1ps
module tb_top;
  logic clk_sys_in = 1'b0, arst_n_in = 1'b0, wr = 1'b0, sel = 1'b0;
  logic [7:0] wdata = 8'h00, addr = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
  logic [7:0] lvl, latch, pout, oe, pup, rdbk;
  int failures = 0, checks = 0;
  // ==========================================================
  // Clock, design and far side
  initial forever #5 clk_sys_in = ~clk_sys_in;
  qbp_port i_dut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .latch_wr_in(wr), .latch_wdata_in(wdata), .latch_out(latch),
    .address_bus_select_in(sel), .mem_addr_in(addr), .pin_in(lvl),
    .pin_out(pout), .pin_oe_out(oe), .pin_pullup_out(pup),
    .pin_level_out(rdbk));
  qbp_pin_model i_pins (.pin_out_in(pout), .pin_oe_in(oe),
    .pin_pullup_in(pup), .ext_en_in(ext_en), .ext_val_in(ext_val),
    .wire_out(lvl));
  // ==========================================================
  // Shared helpers
  // Compares with case equality so an unknown never passes.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Single cycle strobe; returns just after the edge that took it.
  task automatic wr_latch(input logic [7:0] d);
    @(posedge clk_sys_in) #1 wr = 1'b1;
    wdata = d;
    @(posedge clk_sys_in) #1 wr = 1'b0;
  endtask : wr_latch
  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : cycles
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk(latch, 8'hFF);
    chk(oe, 8'h00);
    chk(pup, 8'hFF);
    chk(rdbk, 8'hFF);
    chk(pout, 8'hFF);
    $display("test reset done");
  endtask : t_reset
  task automatic t_low_and_boost();
    wr_latch(8'hA5);
    chk(latch, 8'hA5);
    cycles(5);
    chk(oe, 8'h5A);
    chk(pout & oe, 8'h00);
    chk(rdbk, 8'hA5);
    wr_latch(8'hFF);
    for (int k = 0; k < qbp_pkg::BOOST_CYCLES; k++) begin
      chk(oe, 8'h5A);
      chk(pout & oe, 8'h5A);
      cycles(1);
    end
    chk(oe, 8'h00);
    chk(pup, 8'hFF);
    $display("test low and boost done");
  endtask : t_low_and_boost
  task automatic t_input();
    ext_en = 8'h0F;
    ext_val = 8'h00;
    cycles(4);
    chk(rdbk, 8'hF0);
    chk(latch, 8'hFF);
    ext_en = 8'h00;
    cycles(4);
    chk(rdbk, 8'hFF);
    $display("test input done");
  endtask : t_input
  task automatic t_address();
    sel = 1'b1;
    for (int n = 0; n < 8; n++) begin
      addr = 8'h01 << n;
      #1 chk(pout, addr);
      chk(oe, 8'hFF);
      chk(pup, 8'h00);
      cycles(4);
      chk(rdbk, addr);
    end
    sel = 1'b0;
    $display("test address done");
  endtask : t_address
  task automatic t_addr_write();
    // latch still written while address drives pins
    sel = 1'b1;
    addr = 8'h3C;
    wr_latch(8'h0F);
    chk(latch, 8'h0F);
    chk(pout, 8'h3C);
    chk(pup, 8'h00);
    sel = 1'b0;
    cycles(1);
    chk(pout, 8'h0F);
    chk(oe, 8'hF0);
    chk(pup, 8'h0F);
    $display("test address write done");
  endtask : t_addr_write
  task automatic t_mid_reset();
    // pulldown stands until a reset in mid-run
    wr_latch(8'h00);
    cycles(3);
    chk(oe, 8'hFF);
    chk(pout, 8'h00);
    chk(rdbk, 8'h00);
    arst_n_in = 1'b0;
    cycles(1);
    chk(latch, 8'hFF);
    chk(oe, 8'h00);
    chk(pout, 8'hFF);
    chk(rdbk, 8'hFF);
    arst_n_in = 1'b1;
    cycles(2);
    chk(latch, 8'hFF);
    chk(oe, 8'h00);
    chk(pup, 8'hFF);
    $display("test mid reset done");
  endtask : t_mid_reset
  // ==========================================================
  // Verdict and main sequence
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    cycles(2);
    arst_n_in = 1'b1;
    cycles(4);
    t_reset();
    t_low_and_boost();
    t_input();
    t_addr_write();
    t_address();
    t_mid_reset();
    give_verdict();
  end
endmodule : tb_top
